// ==== src/aas_byte_adder.sv ====
// eight-bit adder slice with carry, half-carry and signed overflow
`timescale 1ns/100ps
module aas_byte_adder (
    input  wire logic [7:0] a_in,
    input  wire logic [7:0] b_in,
    input  wire logic       carry_in,
    output logic      [7:0] sum_out,
    output logic            carry_out,
    output logic            half_out,
    output logic            ovf_out
);
    logic [8:0] full;
    logic [4:0] low;

    always_comb begin
        full      = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in};
        low       = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
        sum_out   = full[7:0];
        carry_out = full[8];
        half_out  = low[4];
        ovf_out   = (a_in[7] == b_in[7]) && (full[7] != a_in[7]);
    end
endmodule

// ==== src/aas_datapath.sv ====
// add/subtract datapath with i/o bit operations behind an avalon slave
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
module aas_datapath (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    input  wire logic [7:0]  io_event_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic      [7:0]  io_flags_out
);
    aas_pkg::aas_state_type state_r, state_nxt;
    logic [2:0]  op_r, op_nxt;
    logic [15:0] dest_r, dest_nxt;
    logic [7:0]  src_r, src_nxt;
    logic [7:0]  imm_r, imm_nxt;
    logic [5:0]  flags_r, flags_nxt;
    logic [5:0]  io_addr_r, io_addr_nxt;
    logic [2:0]  io_bit_r, io_bit_nxt;
    logic [7:0]  io_data_r, io_data_nxt;
    logic [7:0]  io_flags_r, io_flags_nxt;
    logic        refused_r, refused_nxt;
    logic        lo_carry_r, lo_carry_nxt;
    logic        lo_zero_r, lo_zero_nxt;
    logic        wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic [7:0]  add_a, add_b, add_sum;
    logic        add_c, add_cout, add_half, add_ovf;
    logic        is_sub, req, act, wr;
    logic [7:0]  io_tv, io_nv, io_mask, io_clr;
    logic [31:0] wd;

    aas_byte_adder u_adder (
        .a_in      (add_a),
        .b_in      (add_b),
        .carry_in  (add_c),
        .sum_out   (add_sum),
        .carry_out (add_cout),
        .half_out  (add_half),
        .ovf_out   (add_ovf)
    );

    function automatic logic [7:0] merge8(input logic [7:0] old_v,
                                          input logic [7:0] new_v,
                                          input logic       be);
        merge8 = be ? new_v : old_v;
    endfunction

    // adder operand steering; subtraction is a plus inverted b plus one, or plus inverted carry for OP_DIFF_BORROW
    always_comb begin
        add_a  = dest_r[7:0];
        add_b  = src_r;
        add_c  = 1'b0;
        is_sub = 1'b0;
        unique case (op_r)
            aas_pkg::OP_SUM: begin
                add_c = 1'b0;
            end
            aas_pkg::OP_SUM_CARRY: begin
                add_c = flags_r[aas_pkg::FLAG_C];
            end
            aas_pkg::OP_WORD_SUM_IMM: begin
                if (state_r == aas_pkg::ST_WORD_HI) begin
                    add_a = dest_r[15:8];
                    add_b = 8'h00;
                    add_c = lo_carry_r;
                end else begin
                    add_b = imm_r;
                end
            end
            aas_pkg::OP_DIFFERENCE: begin
                add_b  = ~src_r;
                add_c  = 1'b1;
                is_sub = 1'b1;
            end
            aas_pkg::OP_DIFF_CONSTANT: begin
                add_b  = ~imm_r;
                add_c  = 1'b1;
                is_sub = 1'b1;
            end
            aas_pkg::OP_DIFF_BORROW: begin
                add_b  = ~src_r;
                add_c  = ~flags_r[aas_pkg::FLAG_C];
                is_sub = 1'b1;
            end
            aas_pkg::OP_IO_BIT_SET,
            aas_pkg::OP_IO_BIT_CLEAR: begin
                add_c = 1'b0;
            end
        endcase
    end

    // i/o bit operation: read the whole register, change one bit, write all
    always_comb begin
        io_mask = 8'h01 << io_bit_r;
        unique case (io_addr_r)
            aas_pkg::IO_DATA_ADDR: io_tv = io_data_r;
            aas_pkg::IO_FLAG_ADDR: io_tv = io_flags_r;
            default:               io_tv = 8'h00;
        endcase
        if (op_r == aas_pkg::OP_IO_BIT_SET) begin
            io_nv = io_tv | io_mask;
        end else begin
            io_nv = io_tv & ~io_mask;
        end
    end

    always_comb begin
        req          = avs_read_in | avs_write_in;
        act          = req & ~wait_r;
        wr           = act & avs_write_in;
        wd           = avs_writedata_in;
        state_nxt    = state_r;
        op_nxt       = op_r;
        dest_nxt     = dest_r;
        src_nxt      = src_r;
        imm_nxt      = imm_r;
        flags_nxt    = flags_r;
        io_addr_nxt  = io_addr_r;
        io_bit_nxt   = io_bit_r;
        io_data_nxt  = io_data_r;
        io_clr       = 8'h00;
        refused_nxt  = refused_r;
        lo_carry_nxt = lo_carry_r;
        lo_zero_nxt  = lo_zero_r;
        // one wait state per access; stall entirely while busy
        wait_nxt     = ~(req & wait_r & (state_r == aas_pkg::ST_IDLE));
        rdata_nxt    = rdata_r;
        if (req & wait_r) begin
            unique case (avs_address_in)
                aas_pkg::REG_CTRL: rdata_nxt =
                    {30'h0, refused_r, state_r != aas_pkg::ST_IDLE};
                aas_pkg::REG_DEST:     rdata_nxt = {16'h0000, dest_r};
                aas_pkg::REG_OPND:     rdata_nxt = {16'h0000, imm_r, src_r};
                aas_pkg::REG_FLAGS:    rdata_nxt = {26'h0, flags_r};
                aas_pkg::REG_IO_CMD:
                    rdata_nxt = {21'h0, io_bit_r, 2'b00, io_addr_r};
                aas_pkg::REG_IO_DATA:  rdata_nxt = {24'h0, io_data_r};
                aas_pkg::REG_IO_FLAGS: rdata_nxt = {24'h0, io_flags_r};
                default:               rdata_nxt = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            unique case (avs_address_in)
                aas_pkg::REG_CTRL: begin
                    if (avs_byteenable_in[1] & wd[aas_pkg::CTRL_START_BIT]
                        & avs_byteenable_in[0]) begin
                        op_nxt      = wd[aas_pkg::CTRL_OP_LSB +: 3];
                        state_nxt   = aas_pkg::ST_EXEC;
                        refused_nxt = 1'b0;
                    end
                end
                aas_pkg::REG_DEST: begin
                    dest_nxt[7:0]  = merge8(dest_r[7:0], wd[7:0],
                                            avs_byteenable_in[0]);
                    dest_nxt[15:8] = merge8(dest_r[15:8], wd[15:8],
                                            avs_byteenable_in[1]);
                end
                aas_pkg::REG_OPND: begin
                    src_nxt = merge8(src_r, wd[7:0], avs_byteenable_in[0]);
                    imm_nxt = merge8(imm_r, wd[15:8], avs_byteenable_in[1]);
                end
                aas_pkg::REG_FLAGS: begin
                    if (avs_byteenable_in[0]) begin
                        flags_nxt = wd[5:0];
                    end
                end
                aas_pkg::REG_IO_CMD: begin
                    if (avs_byteenable_in[0]) begin
                        io_addr_nxt = wd[5:0];
                    end
                    if (avs_byteenable_in[1]) begin
                        io_bit_nxt = wd[aas_pkg::IO_CMD_BIT_LSB +: 3];
                    end
                end
                aas_pkg::REG_IO_DATA: begin
                    io_data_nxt = merge8(io_data_r, wd[7:0],
                                         avs_byteenable_in[0]);
                end
                aas_pkg::REG_IO_FLAGS: begin
                    io_clr = avs_byteenable_in[0] ? wd[7:0] : 8'h00;
                end
                default: begin
                    io_clr = 8'h00;
                end
            endcase
        end
        unique case (state_r)
            aas_pkg::ST_IDLE: begin
                lo_zero_nxt = lo_zero_r;
            end
            aas_pkg::ST_EXEC: begin
                state_nxt = aas_pkg::ST_IDLE;
                if (op_r == aas_pkg::OP_IO_BIT_SET ||
                    op_r == aas_pkg::OP_IO_BIT_CLEAR) begin
                    if (io_addr_r > aas_pkg::IO_BIT_MAX) begin
                        refused_nxt = 1'b1;
                    end else if (io_addr_r == aas_pkg::IO_DATA_ADDR) begin
                        io_data_nxt = io_nv;
                    end else if (io_addr_r == aas_pkg::IO_FLAG_ADDR) begin
                        // set flags written back as one
                        io_clr = io_nv;
                    end
                end else if (op_r == aas_pkg::OP_WORD_SUM_IMM) begin
                    dest_nxt[7:0] = add_sum;
                    lo_carry_nxt  = add_cout;
                    lo_zero_nxt   = (add_sum == 8'h00);
                    state_nxt     = aas_pkg::ST_WORD_HI;
                end else begin
                    dest_nxt[7:0] = add_sum;
                    flags_nxt[aas_pkg::FLAG_C] = add_cout ^ is_sub;
                    flags_nxt[aas_pkg::FLAG_H] = add_half ^ is_sub;
                    flags_nxt[aas_pkg::FLAG_Z] = (add_sum == 8'h00);
                    flags_nxt[aas_pkg::FLAG_N] = add_sum[7];
                    flags_nxt[aas_pkg::FLAG_V] = add_ovf;
                end
            end
            aas_pkg::ST_WORD_HI: begin
                state_nxt      = aas_pkg::ST_IDLE;
                dest_nxt[15:8] = add_sum;
                flags_nxt[aas_pkg::FLAG_C] = add_cout;
                flags_nxt[aas_pkg::FLAG_Z] = lo_zero_r & (add_sum == 8'h00);
                flags_nxt[aas_pkg::FLAG_N] = add_sum[7];
                flags_nxt[aas_pkg::FLAG_V] = add_ovf;
                flags_nxt[aas_pkg::FLAG_S] = add_sum[7] ^ add_ovf;
            end
        endcase
        // a new event beats a clear in the same cycle
        io_flags_nxt = (io_flags_r & ~io_clr) | io_event_in;
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r    <= aas_pkg::ST_IDLE;
            op_r       <= aas_pkg::OP_SUM;
            dest_r     <= aas_pkg::DEST_RST;
            src_r      <= aas_pkg::BYTE_RST;
            imm_r      <= aas_pkg::BYTE_RST;
            flags_r    <= aas_pkg::FLAGS_RST;
            io_addr_r  <= 6'h00;
            io_bit_r   <= 3'h0;
            io_data_r  <= aas_pkg::BYTE_RST;
            io_flags_r <= aas_pkg::BYTE_RST;
            refused_r  <= 1'b0;
            lo_carry_r <= 1'b0;
            lo_zero_r  <= 1'b0;
            wait_r     <= 1'b1;
            rdata_r    <= 32'h0000_0000;
        end else begin
            state_r    <= state_nxt;
            op_r       <= op_nxt;
            dest_r     <= dest_nxt;
            src_r      <= src_nxt;
            imm_r      <= imm_nxt;
            flags_r    <= flags_nxt;
            io_addr_r  <= io_addr_nxt;
            io_bit_r   <= io_bit_nxt;
            io_data_r  <= io_data_nxt;
            io_flags_r <= io_flags_nxt;
            refused_r  <= refused_nxt;
            lo_carry_r <= lo_carry_nxt;
            lo_zero_r  <= lo_zero_nxt;
            wait_r     <= wait_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    assign avs_readdata_out    = rdata_r;
    assign avs_waitrequest_out = wait_r;
    assign io_flags_out        = io_flags_r;
endmodule

// ==== src/aas_pkg.sv ====
// constants shared by the add/subtract datapath and its bus slave
package aas_pkg;
    // register word addresses on the avalon slave
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_DEST     = 4'h1;
    localparam logic [3:0] REG_OPND     = 4'h2;
    localparam logic [3:0] REG_FLAGS    = 4'h3;
    localparam logic [3:0] REG_IO_CMD   = 4'h4;
    localparam logic [3:0] REG_IO_DATA  = 4'h5;
    localparam logic [3:0] REG_IO_FLAGS = 4'h6;

    // control register fields
    localparam int CTRL_OP_LSB    = 0;
    localparam int CTRL_START_BIT = 8;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_REF_BIT   = 1;

    // operation codes in the control register
    localparam logic [2:0] OP_SUM             = 3'h0;
    localparam logic [2:0] OP_SUM_CARRY       = 3'h1;
    localparam logic [2:0] OP_WORD_SUM_IMM    = 3'h2;
    localparam logic [2:0] OP_DIFFERENCE      = 3'h3;
    localparam logic [2:0] OP_DIFF_CONSTANT   = 3'h4;
    localparam logic [2:0] OP_DIFF_BORROW     = 3'h5;
    localparam logic [2:0] OP_IO_BIT_SET      = 3'h6;
    localparam logic [2:0] OP_IO_BIT_CLEAR    = 3'h7;

    // status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;

    // i/o space reached by the single-bit operations
    localparam logic [5:0] IO_BIT_MAX   = 6'h1F;
    localparam logic [5:0] IO_DATA_ADDR = 6'h10;
    localparam logic [5:0] IO_FLAG_ADDR = 6'h11;
    localparam int IO_CMD_BIT_LSB = 8;

    // reset values
    localparam logic [15:0] DEST_RST  = 16'h0000;
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [5:0]  FLAGS_RST = 6'h00;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_WORD_HI
    } aas_state_type;
endpackage

// ==== tb/aas_datapath_chk.sv ====
// concurrent checks on the add/subtract datapath ports
`timescale 1ns/100ps
module aas_datapath_chk (
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    input wire logic [3:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [7:0]  io_event_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic [7:0]  io_flags_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic ack;
    logic word_go;
    assign ack = !avs_waitrequest_out;
    assign word_go = ack && avs_write_in
        && avs_writedata_in[aas_pkg::CTRL_START_BIT]
        && avs_address_in == aas_pkg::REG_CTRL
        && avs_writedata_in[2:0] == aas_pkg::OP_WORD_SUM_IMM
        && avs_byteenable_in[1:0] == 2'h3;
    property p_ack_one;
        $fell(avs_waitrequest_out) |=> avs_waitrequest_out;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_ack_req;
        ack |-> (avs_read_in ^ avs_write_in);
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack without request");
    property p_idle_wait;
        !(avs_read_in || avs_write_in) |-> avs_waitrequest_out;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("idle wait low");
    property p_ev_set;
        io_event_in != 8'h00 |=>
            (io_flags_out & $past(io_event_in)) == $past(io_event_in);
    endproperty
    a_ev_set: assert property (p_ev_set) else $error("event lost");
    property p_w1c;
        ack && avs_write_in && avs_address_in == aas_pkg::REG_IO_FLAGS
            && avs_byteenable_in[0] && io_event_in == 8'h00 |=>
            io_flags_out == ($past(io_flags_out)
                & ~$past(avs_writedata_in[7:0]));
    endproperty
    a_w1c: assert property (p_w1c) else $error("w1c wrong");
    property p_unmapped;
        ack && avs_read_in && avs_address_in > 4'h6 |->
            avs_readdata_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped nonzero");
    property p_flags_hi;
        ack && avs_read_in && avs_address_in == aas_pkg::REG_FLAGS |->
            avs_readdata_out[31:6] == 26'h0;
    endproperty
    a_flags_hi: assert property (p_flags_hi)
        else $error("flag pad");
    property p_io_rd;
        ack && avs_read_in && avs_address_in == aas_pkg::REG_IO_FLAGS |->
            avs_readdata_out[7:0] == $past(io_flags_out);
    endproperty
    a_io_rd: assert property (p_io_rd) else $error("io flag read");
    // word op holds the core for two steps; a request raised right after
    // the start may not be granted before the fourth cycle
    property p_word_stall;
        word_go |=> avs_waitrequest_out [*3];
    endproperty
    a_word_stall: assert property (p_word_stall)
        else $error("no stall");
    c_word: cover property (word_go);
    c_w1c: cover property (ack && avs_write_in
        && avs_address_in == aas_pkg::REG_IO_FLAGS);
    c_unmapped: cover property (ack && avs_read_in && avs_address_in > 4'h6);
endmodule

bind aas_datapath aas_datapath_chk u_aas_datapath_chk (
    .clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .io_event_in,
    .avs_readdata_out, .avs_waitrequest_out, .io_flags_out
);

// ==== tb/aas_event_src.sv ====
// peripherals raising i/o status flags, one-cycle set pulses
`timescale 1ns/100ps
module aas_event_src (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic [7:0] fire_in,
    output logic      [7:0] io_event_out
);
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            io_event_out <= 8'h00;
        end else begin
            io_event_out <= fire_in;
        end
    end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the add/subtract datapath
`timescale 1ns/100ps
module tb;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [7:0]  fire = 8'h00;
    logic [7:0]  ev;
    logic [31:0] rdat;
    logic        wreq;
    logic [7:0]  iof;
    logic [31:0] got;
    logic [21:0] ex;
    int          err_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [2:0]  t_op [7] = '{aas_pkg::OP_SUM, aas_pkg::OP_SUM_CARRY,
        aas_pkg::OP_WORD_SUM_IMM, aas_pkg::OP_WORD_SUM_IMM,
        aas_pkg::OP_DIFFERENCE, aas_pkg::OP_DIFF_CONSTANT,
        aas_pkg::OP_DIFF_BORROW};
    logic [15:0] t_d [7] = '{16'h007F, 16'h12FF, 16'hFFFF, 16'h7FFF,
        16'h0000, 16'h0080, 16'h0001};
    logic [7:0]  t_s [7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h55, 8'h00};
    logic [7:0]  t_k [7] = '{8'hAA, 8'h00, 8'h01, 8'h80, 8'h00, 8'h01, 8'h00};
    logic [5:0]  t_f [7] = '{6'h00, 6'h01, 6'h20, 6'h00, 6'h10, 6'h00, 6'h01};

    always #50 clk_in = ~clk_in;

    aas_event_src u_aas_event_src (.clk_in, .rst_b_in, .fire_in(fire),
        .io_event_out(ev));
    aas_datapath u_aas_datapath (.clk_in, .rst_b_in, .avs_address_in(adr),
        .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdat),
        .avs_byteenable_in(4'hF), .io_event_in(ev), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .io_flags_out(iof));

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] g, logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // request held until the edge that samples waitrequest low
    task automatic acc(logic w, logic [3:0] a, logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        wr_en <= w;
        rd_en <= !w;
        do begin
            @(posedge clk_in);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        got = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        if (n >= 100) chk("bus answer", 32'h0, 32'h1);
        @(posedge clk_in);
    endtask

    task automatic rchk(string nm, logic [3:0] a, logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(nm, got, e);
    endtask

    // reserved control bits always written as zero
    task automatic go(logic [2:0] op);
        acc(1'b1, aas_pkg::REG_CTRL, {23'h0, 1'b1, 5'h0, op});
    endtask

    task automatic bitop(logic [2:0] op, logic [5:0] a, logic [2:0] b);
        acc(1'b1, aas_pkg::REG_IO_CMD, {21'h0, b, 2'h0, a});
        go(op);
    endtask

    task automatic pulse(logic [7:0] v);
        fire <= v;
        @(posedge clk_in);
        fire <= 8'h00;
        repeat (2) @(posedge clk_in);
    endtask

    // subtraction runs as a plus inverted b plus inverted borrow
    function automatic logic [21:0] model(logic [2:0] op, logic [15:0] d,
        logic [7:0] s, logic [7:0] k, logic [5:0] f);
        logic        sb;
        logic        ci;
        logic        v;
        logic [7:0]  b;
        logic [8:0]  r;
        logic [4:0]  h;
        logic [16:0] w;
        if (op == aas_pkg::OP_WORD_SUM_IMM) begin
            w = {1'b0, d} + {9'h0, k};
            v = !d[15] && w[15];
            return {f[5], w[15] ^ v, v, w[15], w[15:0] == 16'h0, w[16],
                w[15:0]};
        end
        sb = op inside {aas_pkg::OP_DIFFERENCE, aas_pkg::OP_DIFF_CONSTANT,
            aas_pkg::OP_DIFF_BORROW};
        ci = (op == aas_pkg::OP_SUM_CARRY || op == aas_pkg::OP_DIFF_BORROW)
            && f[0];
        b = (op == aas_pkg::OP_DIFF_CONSTANT) ? k : s;
        b = sb ? ~b : b;
        ci = ci ^ sb;
        r = {1'b0, d[7:0]} + {1'b0, b} + {8'h0, ci};
        h = {1'b0, d[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        v = (d[7] == b[7]) && (r[7] != d[7]);
        return {h[4] ^ sb, f[4], v, r[7], r[7:0] == 8'h0, r[8] ^ sb,
            d[15:8], r[7:0]};
    endfunction

    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        repeat (8) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        rchk("dest reset", aas_pkg::REG_DEST, 32'h0);
        rchk("flags reset", aas_pkg::REG_FLAGS, 32'h0);
        // reserved addresses are only ever read, never written
        rchk("unmapped 7", 4'h7, 32'h0);
        rchk("unmapped F", 4'hF, 32'h0);
        for (int i = 0; i < 7; i++) begin
            ex = model(t_op[i], t_d[i], t_s[i], t_k[i], t_f[i]);
            acc(1'b1, aas_pkg::REG_DEST, {16'h0, t_d[i]});
            acc(1'b1, aas_pkg::REG_OPND, {16'h0, t_k[i], t_s[i]});
            acc(1'b1, aas_pkg::REG_FLAGS, {26'h0, t_f[i]});
            go(t_op[i]);
            rchk("dest", aas_pkg::REG_DEST,
                {16'h0, ex[15:0]});
            rchk("flags", aas_pkg::REG_FLAGS, {26'h0, ex[21:16]});
        end
        pulse(8'h05);
        chk("io flags set", {24'h0, iof}, 32'h5);
        bitop(aas_pkg::OP_IO_BIT_SET, aas_pkg::IO_FLAG_ADDR, 3'h1);
        rchk("bit op flags", aas_pkg::REG_IO_FLAGS, 32'h0);
        acc(1'b1, aas_pkg::REG_IO_DATA, 32'hFF);
        bitop(aas_pkg::OP_IO_BIT_CLEAR, aas_pkg::IO_DATA_ADDR, 3'h3);
        rchk("bit clear", aas_pkg::REG_IO_DATA, 32'hF7);
        bitop(aas_pkg::OP_IO_BIT_SET, aas_pkg::IO_BIT_MAX, 3'h0);
        rchk("top address", aas_pkg::REG_CTRL, 32'h0);
        bitop(aas_pkg::OP_IO_BIT_SET, 6'h20, 3'h3);
        rchk("refused", aas_pkg::REG_CTRL, 32'h2);
        rchk("refused data", aas_pkg::REG_IO_DATA, 32'hF7);
        bitop(aas_pkg::OP_IO_BIT_SET, aas_pkg::IO_DATA_ADDR, 3'h3);
        rchk("refused cleared", aas_pkg::REG_CTRL, 32'h0);
        rchk("bit set", aas_pkg::REG_IO_DATA, 32'hFF);
        pulse(8'hF0);
        acc(1'b1, aas_pkg::REG_IO_FLAGS, 32'h30);
        rchk("w1c one", aas_pkg::REG_IO_FLAGS, 32'hC0);
        acc(1'b1, aas_pkg::REG_IO_FLAGS, 32'h0);
        rchk("w1c zero", aas_pkg::REG_IO_FLAGS, 32'hC0);
        chk("io flags port", {24'h0, iof}, 32'hC0);
        end_sim();
    end
endmodule
